//--- dcsf_fifo.sv
// buffer fifo and nine-bit synchronous fifo top with programmable flags
`timescale 1ns/1ns
`default_nettype none

// generic show-ahead fifo with valid/ready on both sides
module dcsf_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 32,
  parameter int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [CW-1:0] count
);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  wire push;
  wire pop;
  wire full;

  // pointer advance with wrap at any depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // handshake decode, a pop frees room for a push in the same cycle
  assign full = (count == CW'(DEPTH));
  assign in_ready = !full || out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      if (push && !pop) count <= CW'(count + 1'b1);
      else if (pop && !push) count <= CW'(count - 1'b1);
    end
  end
endmodule

// nine-bit fifo: main array feeds a 32-word stage that serves reads
module dcsf_sync_fifo #(
  parameter int DEPTH = dcsf_pkg::DEPTH_DEFAULT,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [8:0] D,
  input wire logic WRITE_ENABLE_PRIMARY_N,
  input wire logic WRITE_ENABLE_SECOND_OR_OFFSET_LOAD,
  input wire logic READ_ENABLE_A_N,
  input wire logic READ_ENABLE_B_N,
  input wire logic OUTPUT_ENABLE_N,
  output logic [8:0] Q,
  output logic Q_OE,
  output logic EMPTY_FLAG_N,
  output logic FULL_FLAG_N,
  output logic ALMOST_EMPTY_FLAG_N,
  output logic ALMOST_FULL_FLAG_N
);
  localparam int MAIN_DEPTH = DEPTH - dcsf_pkg::STAGE_DEPTH;
  localparam int SCW = $clog2(dcsf_pkg::STAGE_DEPTH + 1);
  localparam logic [15:0] OFFSET_MASK = 16'(DEPTH - 1);

  logic offset_mode;
  logic [7:0] almost_empty_offset_low;
  logic [7:0] almost_empty_offset_high;
  logic [7:0] almost_full_offset_low;
  logic [7:0] almost_full_offset_high;
  dcsf_pkg::dcsf_offset_sel_t offset_sel;
  logic [CW-1:0] count;
  dcsf_pkg::dcsf_req_t req;
  wire load_active;
  wire read_req;
  wire write_accept;
  wire read_accept;
  wire main_in_ready;
  wire main_valid;
  wire [8:0] main_data;
  wire stage_ready;
  wire stage_valid;
  wire [8:0] stage_data;
  wire [SCW-1:0] stage_count;
  wire stage_push;
  wire stage_next_valid;
  wire [CW-1:0] next_count;
  wire [16:0] offset_n;
  wire [16:0] offset_m;
  wire [16:0] count_wide;
  wire [7:0] offset_read_value;

  // next register in the offset sequence
  function automatic dcsf_pkg::dcsf_offset_sel_t next_sel(
    input dcsf_pkg::dcsf_offset_sel_t s
  );
    case (s)
      dcsf_pkg::DCSF_EMPTY_LOW: next_sel = dcsf_pkg::DCSF_EMPTY_HIGH;
      dcsf_pkg::DCSF_EMPTY_HIGH: next_sel = dcsf_pkg::DCSF_FULL_LOW;
      dcsf_pkg::DCSF_FULL_LOW: next_sel = dcsf_pkg::DCSF_FULL_HIGH;
      dcsf_pkg::DCSF_FULL_HIGH: next_sel = dcsf_pkg::DCSF_EMPTY_LOW;
      default: next_sel = dcsf_pkg::DCSF_EMPTY_LOW;
    endcase
  endfunction

  // request decode from the control pins
  assign load_active = offset_mode && !WRITE_ENABLE_SECOND_OR_OFFSET_LOAD;
  assign read_req = !READ_ENABLE_A_N && !READ_ENABLE_B_N;
  // in offset mode the pin is high outside loading, so one term serves both
  assign req.fifo_write = !WRITE_ENABLE_PRIMARY_N &&
    WRITE_ENABLE_SECOND_OR_OFFSET_LOAD;
  assign req.fifo_read = read_req && !load_active;
  assign req.offset_write = load_active && !WRITE_ENABLE_PRIMARY_N;
  assign req.offset_read = load_active && read_req;

  // flag gating of accepted transfers
  assign write_accept = req.fifo_write && FULL_FLAG_N;
  assign read_accept = req.fifo_read && EMPTY_FLAG_N && stage_valid;

  // main array, drained into the stage whenever the stage has room
  dcsf_fifo #(
    .W(dcsf_pkg::DATA_W),
    .DEPTH(MAIN_DEPTH)
  ) u_main (
    .clk(CLK),
    .rst_n(RESET_N),
    .in_valid(write_accept),
    .in_ready(main_in_ready),
    .in_data(D),
    .out_valid(main_valid),
    .out_ready(stage_ready),
    .out_data(main_data),
    .count()
  );

  // 32-word stage serving the read port, stalls the mover when full and not read in the same cycle
  dcsf_fifo #(
    .W(dcsf_pkg::DATA_W),
    .DEPTH(dcsf_pkg::STAGE_DEPTH)
  ) u_stage (
    .clk(CLK),
    .rst_n(RESET_N),
    .in_valid(main_valid),
    .in_ready(stage_ready),
    .in_data(main_data),
    .out_valid(stage_valid),
    .out_ready(read_accept),
    .out_data(stage_data),
    .count(stage_count)
  );

  // occupancy and threshold arithmetic
  assign stage_push = main_valid && stage_ready;
  assign stage_next_valid = stage_push || (stage_count > SCW'(1)) ||
    (stage_valid && !read_accept);
  assign next_count = CW'(count + CW'(write_accept) - CW'(read_accept));
  assign count_wide = 17'(next_count);
  assign offset_n = {1'b0,
    {almost_empty_offset_high, almost_empty_offset_low} & OFFSET_MASK};
  assign offset_m = {1'b0,
    {almost_full_offset_high, almost_full_offset_low} & OFFSET_MASK};
  assign offset_read_value =
    (offset_sel == dcsf_pkg::DCSF_EMPTY_LOW) ? almost_empty_offset_low :
    (offset_sel == dcsf_pkg::DCSF_EMPTY_HIGH) ? almost_empty_offset_high :
    (offset_sel == dcsf_pkg::DCSF_FULL_LOW) ? almost_full_offset_low :
    almost_full_offset_high;

  // mode strap caught while reset is held
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      offset_mode <= !WRITE_ENABLE_SECOND_OR_OFFSET_LOAD;
    end
  end

  // offset registers and their sequence position
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      almost_empty_offset_low <= dcsf_pkg::OFFSET_LOW_RESET;
      almost_empty_offset_high <= dcsf_pkg::OFFSET_HIGH_RESET;
      almost_full_offset_low <= dcsf_pkg::OFFSET_LOW_RESET;
      almost_full_offset_high <= dcsf_pkg::OFFSET_HIGH_RESET;
      offset_sel <= dcsf_pkg::DCSF_EMPTY_LOW;
    end else begin
      if (req.offset_write) begin
        case (offset_sel)
          dcsf_pkg::DCSF_EMPTY_LOW: almost_empty_offset_low <= D[7:0];
          dcsf_pkg::DCSF_EMPTY_HIGH: almost_empty_offset_high <= D[7:0];
          dcsf_pkg::DCSF_FULL_LOW: almost_full_offset_low <= D[7:0];
          dcsf_pkg::DCSF_FULL_HIGH: almost_full_offset_high <= D[7:0];
          default: almost_empty_offset_low <= D[7:0];
        endcase
      end
      // position only moves on access, so it survives load going high
      if (req.offset_write || req.offset_read) begin
        offset_sel <= next_sel(offset_sel);
      end
    end
  end

  // output register, holds the last read while empty
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      Q <= dcsf_pkg::Q_RESET;
    end else if (req.offset_read) begin
      Q <= {1'b0, offset_read_value};
    end else if (read_accept) begin
      Q <= stage_data;
    end
  end

  // pin drive enable follows the active-low enable
  always_ff @(posedge CLK) begin
    if (!RESET_N) Q_OE <= 1'b0;
    else Q_OE <= !OUTPUT_ENABLE_N;
  end

  // occupancy and registered flags
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      count <= '0;
      EMPTY_FLAG_N <= 1'b0;
      FULL_FLAG_N <= 1'b1;
      ALMOST_EMPTY_FLAG_N <= 1'b0;
      ALMOST_FULL_FLAG_N <= 1'b1;
    end else begin
      count <= next_count;
      EMPTY_FLAG_N <= stage_next_valid;
      FULL_FLAG_N <= (next_count != CW'(DEPTH));
      ALMOST_EMPTY_FLAG_N <= (count_wide > offset_n);
      ALMOST_FULL_FLAG_N <= ((count_wide + offset_m) < 17'(DEPTH));
    end
  end

  // one clock serves both ports, so no pointer ever crosses a domain
  // and the binary counts above are already glitch safe

  // main array room is implied by the full flag
  wire unused_ok = main_in_ready;
endmodule

`default_nettype wire

//--- dcsf_pkg.sv
// constants, types and state codes for the nine-bit synchronous fifo
// How it works
// - storage holds 1K or 2K nine-bit words behind separate read and write pointers
// - reset empties the fifo, empty flag low, data outputs low after release
// - primary write enable low and second enable high stores a word each edge
// - both read enables low presents the next stored word each edge
// - output enable low drives output register contents onto the data pins
// - output enable high floats all nine data pins
// - writes when full and reads when empty are ignored entirely
// - an empty fifo keeps the last valid read word on its outputs
// - dual-purpose pin caught in reset picks second enable or offset load mode
// - in offset mode the primary enable alone writes fifo data sequentially
// - four 8-bit offset registers reached over the data pins while load is low
// - load and primary enable low write offsets in turn, fifth edge wraps
// - offset sequence position survives load going high and continues later
// - load low with both read enables low reads offsets in the same sequence
// - both almost offsets default to seven after reset
// - almost-empty flag low when unread words are the offset or fewer
// - almost-full flag low when unread words reach depth minus the offset
// - full flag low when every location is used, blocking all writes; the code still accepts offset register writes while load is low
// - empty flag low when nothing is unread, blocking all reads; the code still performs offset register reads while load is low
package dcsf_pkg;
  localparam int DATA_W = 9;
  localparam int OFFSET_W = 8;
  localparam int DEPTH_DEFAULT = 1024;
  localparam int STAGE_DEPTH = 32;
  localparam logic [7:0] OFFSET_LOW_RESET = 8'h07;
  localparam logic [7:0] OFFSET_HIGH_RESET = 8'h00;
  localparam logic [8:0] Q_RESET = 9'h000;

  // offset register sequence, gray coded along the cycle
  typedef enum logic [1:0] {
    DCSF_EMPTY_LOW = 2'b00,
    DCSF_EMPTY_HIGH = 2'b01,
    DCSF_FULL_LOW = 2'b11,
    DCSF_FULL_HIGH = 2'b10
  } dcsf_offset_sel_t;

  // decoded requests from the control pins
  typedef struct packed {
    logic fifo_write;
    logic fifo_read;
    logic offset_write;
    logic offset_read;
  } dcsf_req_t;
endpackage

//--- dcsf_chk.sv
// port checker for the nine-bit fifo top
`timescale 1ns/1ns
`default_nettype none
module dcsf_chk #(
  parameter int DEPTH = 1024,
  parameter int CW = 11
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [8:0] D,
  input wire logic WRITE_ENABLE_PRIMARY_N,
  input wire logic WRITE_ENABLE_SECOND_OR_OFFSET_LOAD,
  input wire logic READ_ENABLE_A_N,
  input wire logic READ_ENABLE_B_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [8:0] Q,
  input wire logic Q_OE,
  input wire logic EMPTY_FLAG_N,
  input wire logic FULL_FLAG_N,
  input wire logic ALMOST_EMPTY_FLAG_N,
  input wire logic ALMOST_FULL_FLAG_N
);
  logic [CW-1:0] cnt;
  logic wr_ok;
  logic rd_ok;
  logic mode_hi;
  // fifo writes and reads accepted while the dual-purpose pin is high
  assign mode_hi = WRITE_ENABLE_SECOND_OR_OFFSET_LOAD;
  assign wr_ok = !WRITE_ENABLE_PRIMARY_N && mode_hi && FULL_FLAG_N;
  assign rd_ok = !READ_ENABLE_A_N && !READ_ENABLE_B_N && mode_hi
    && EMPTY_FLAG_N;
  // word count kept beside the design
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(wr_ok) - CW'(rd_ok);
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  reset_state_a: assert property ($rose(RESET_N) |-> Q == 9'h000
    && !EMPTY_FLAG_N && FULL_FLAG_N) else $error("reset state wrong");
  oe_lag_a: assert property ($past(RESET_N) |->
    Q_OE == !$past(OUTPUT_ENABLE_N)) else $error("output enable lag");
  full_hold_a: assert property (!FULL_FLAG_N && READ_ENABLE_A_N |=>
    !FULL_FLAG_N) else $error("full flag dropped without read");
  full_count_a: assert property (FULL_FLAG_N == (cnt != CW'(DEPTH)))
    else $error("full flag disagrees with count");
  empty_zero_a: assert property (cnt == '0 |-> !EMPTY_FLAG_N)
    else $error("empty flag high with no words");
  empty_rise_a: assert property ($past(cnt) != '0 && cnt != '0
    |-> EMPTY_FLAG_N) else $error("empty flag low with words");
  q_keep_a: assert property (!EMPTY_FLAG_N && mode_hi |=> $stable(Q))
    else $error("output changed while empty");
  q_cause_a: assert property (!$stable(Q) |->
    $past(!READ_ENABLE_A_N && !READ_ENABLE_B_N)) else $error("q moved");
  cover property (!FULL_FLAG_N && !WRITE_ENABLE_PRIMARY_N);
  cover property (!EMPTY_FLAG_N && !READ_ENABLE_A_N && !READ_ENABLE_B_N);
  cover property (!mode_hi && !WRITE_ENABLE_PRIMARY_N);
endmodule
bind dcsf_sync_fifo dcsf_chk #(.DEPTH(DEPTH), .CW(CW)) chk_i (
  .CLK(CLK), .RESET_N(RESET_N), .D(D),
  .WRITE_ENABLE_PRIMARY_N(WRITE_ENABLE_PRIMARY_N),
  .WRITE_ENABLE_SECOND_OR_OFFSET_LOAD(WRITE_ENABLE_SECOND_OR_OFFSET_LOAD),
  .READ_ENABLE_A_N(READ_ENABLE_A_N), .READ_ENABLE_B_N(READ_ENABLE_B_N),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .Q(Q), .Q_OE(Q_OE),
  .EMPTY_FLAG_N(EMPTY_FLAG_N), .FULL_FLAG_N(FULL_FLAG_N),
  .ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N),
  .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N));
`default_nettype wire

//--- dcsf_bus_model.sv
// consumer side data bus, inverse of last value once released
`timescale 1ns/1ns
`default_nettype none
module dcsf_bus_model (
  input wire logic clk,
  input wire logic [8:0] q,
  input wire logic q_oe,
  output logic [8:0] pins
);
  logic [8:0] last;
  // remember the last driven value
  always_ff @(posedge clk) begin
    if (q_oe) begin
      last <= q;
    end
  end
  // released bus is no longer the old value
  assign pins = q_oe ? q : ~last;
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the nine-bit fifo
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int DEPTH = 64;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [8:0] D = 9'h000;
  logic wen_n = 1'b1;
  logic ld = 1'b1;
  logic ra_n = 1'b1;
  logic rb_n = 1'b1;
  logic oe_n = 1'b0;
  logic [8:0] q;
  logic [8:0] pins;
  logic q_oe, ef_n, ff_n, ae_n, af_n;
  int failures = 0;
  int n_tests = 0;
  always #5 CLK = ~CLK;
  dcsf_sync_fifo #(.DEPTH(DEPTH)) uut (.CLK(CLK), .RESET_N(RESET_N),
    .D(D), .WRITE_ENABLE_PRIMARY_N(wen_n),
    .WRITE_ENABLE_SECOND_OR_OFFSET_LOAD(ld), .READ_ENABLE_A_N(ra_n),
    .READ_ENABLE_B_N(rb_n), .OUTPUT_ENABLE_N(oe_n), .Q(q), .Q_OE(q_oe),
    .EMPTY_FLAG_N(ef_n), .FULL_FLAG_N(ff_n), .ALMOST_EMPTY_FLAG_N(ae_n),
    .ALMOST_FULL_FLAG_N(af_n));
  dcsf_bus_model bus (.clk(CLK), .q(q), .q_oe(q_oe), .pins(pins));
  // a single device, its own flags are the composite flags
  // compare and count
  task automatic chk(input string what, input logic [8:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // controls change at the falling edge, results read after the rise
  task automatic drv(input logic w, l, r, input logic [8:0] d);
    @(negedge CLK);
    wen_n = w;
    ld = l;
    ra_n = r;
    rb_n = r;
    D = d;
    @(posedge CLK);
    #1;
  endtask
  task automatic rst(input logic l);
    @(negedge CLK);
    RESET_N = 1'b0;
    wen_n = 1'b1;
    ra_n = 1'b1;
    rb_n = 1'b1;
    ld = l;
    repeat (16) @(negedge CLK);
    RESET_N = 1'b1;
    ld = 1'b1;
  endtask
  // fill past full, then drain past empty
  task automatic t_fill();
    chk("q reset", q, 9'h000);
    chk("flags reset", {5'h00, ef_n, ff_n, ae_n, af_n}, 9'h005);
    for (int i = 0; i < DEPTH; i++) begin
      drv(1'b0, 1'b1, 1'b1, 9'(i * 5));
      chk("almost full", {8'h00, af_n}, {8'h00, i + 1 < DEPTH - 7});
      chk("full", {8'h00, ff_n}, {8'h00, i + 1 < DEPTH});
    end
    drv(1'b0, 1'b1, 1'b1, 9'h1ff);
    chk("full kept", {8'h00, ff_n}, 9'h000);
    for (int i = 0; i < DEPTH; i++) begin
      drv(1'b1, 1'b1, 1'b0, 9'h000);
      chk("read data", q, 9'(i * 5));
      chk("almost empty", {8'h00, ae_n}, {8'h00, DEPTH - 1 - i > 7});
      chk("empty", {8'h00, ef_n}, {8'h00, i != DEPTH - 1});
    end
    drv(1'b1, 1'b1, 1'b0, 9'h000);
    chk("last kept", q, 9'((DEPTH - 1) * 5));
  endtask
  // output enable floats and drives the pins
  task automatic t_oe();
    @(negedge CLK);
    oe_n = 1'b1;
    drv(1'b1, 1'b1, 1'b1, 9'h000);
    chk("q_oe off", {8'h00, q_oe}, 9'h000);
    chk("pins released", pins, ~9'((DEPTH - 1) * 5));
    @(negedge CLK);
    oe_n = 1'b0;
    drv(1'b1, 1'b1, 1'b1, 9'h000);
    chk("pins", pins, 9'((DEPTH - 1) * 5));
  endtask
  // offset writes wrap, survive a data write, read back in turn
  task automatic t_offsets();
    logic [8:0] wv[5] = '{9'h011, 9'h000, 9'h033, 9'h044, 9'h002};
    logic [8:0] rv[4] = '{9'h000, 9'h033, 9'h044, 9'h002};
    rst(1'b0);
    for (int k = 0; k < 5; k++) begin
      drv(1'b0, 1'b0, 1'b1, wv[k]);
    end
    drv(1'b0, 1'b1, 1'b1, 9'h1c3);
    chk("ae offset", {8'h00, ae_n}, 9'h000);
    chk("af offset", {8'h00, af_n}, 9'h001);
    // offset writes and reads are kept apart in time
    for (int k = 0; k < 4; k++) begin
      drv(1'b1, 1'b0, 1'b0, 9'h000);
      chk("offset read", q, rv[k]);
    end
    drv(1'b1, 1'b1, 1'b0, 9'h000);
    chk("data in offset mode", q, 9'h1c3);
  endtask
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  initial begin
    rst(1'b1);
    t_fill();
    t_oe();
    t_offsets();
    stop_test();
  end
endmodule
`default_nettype wire
